// [slpi_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module slpi_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic      [W-1:0] out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("slpi_fifo: DEPTH must be a power of two, at least 2");
        end
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0]   cnt_reg;
    logic [AW:0]   cnt_next;
    logic          push;
    logic          pop;

    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_valid_o = cnt_reg != '0;
    assign out_data_o  = mem[rp_reg];
    assign cnt_next    = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_reg     <= '0;
            rp_reg     <= '0;
            cnt_reg    <= '0;
            in_ready_o <= 1'b0;
        end else begin
            wp_reg     <= wp_reg + AW'(push);
            rp_reg     <= rp_reg + AW'(pop);
            cnt_reg    <= cnt_next;
            in_ready_o <= cnt_next != (AW+1)'(DEPTH);
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp_reg] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// [slpi_link_model.sv]
`timescale 1ns/100ps
`default_nettype none
module slpi_link_model (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    pwr_i,
    input  wire slpi_pkg::slpi_pin_out_s phy_i,
    output slpi_pkg::slpi_pin_in_s       pins_o,
    input  wire logic                    go_i,
    input  wire logic [16:0]             req_i,
    input  wire logic [7:0]              tx_i,
    output logic                         rx_stb_o,
    output logic [7:0]                   rx_o
);
    logic        sclk_q, oe, pend;
    logic [1:0]  ctl;
    logic [7:0]  d;
    logic [16:0] sh;
    logic [2:0]  ph;
    // A released line shows the inverse of its last value.
    // no isolation barrier, so outputs are driven plainly.
    always_comb begin
        pins_o.ctl = phy_i.ctl_oe ? phy_i.ctl : (oe ? ctl : ~phy_i.ctl);
        pins_o.d = phy_i.d_oe ? phy_i.d : (oe ? d : ~phy_i.d);
        pins_o.link_service_request_line = sh[16];
        pins_o.pwr = pwr_i;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {sclk_q, oe, pend, ctl, d, sh, ph, rx_stb_o, rx_o} <= '0;
        end else begin
            sclk_q <= phy_i.sclk;
            rx_stb_o <= 1'b0;
            if (go_i) pend <= 1'b1;
            if (phy_i.sclk && !sclk_q) begin
                sh <= pend ? req_i : {sh[15:0], 1'b0};
                pend <= 1'b0;
                rx_stb_o <= phy_i.ctl_oe && phy_i.ctl == slpi_pkg::CTL_RECV;
                rx_o <= phy_i.d;
                if (ph == 3'h0 && phy_i.ctl_oe && phy_i.ctl == slpi_pkg::CTL_GRANT) ph <= 3'h1;
                else if (ph != 3'h0) ph <= ph + 3'h1;
                if (ph == 3'h1) {oe, ctl} <= {1'b1, slpi_pkg::CTL_HOLD};
                if (ph >= 3'h2 && ph <= 3'h4) ctl <= slpi_pkg::CTL_XMIT;
                d <= tx_i + 8'(ph - 3'h2);
                if (ph == 3'h5) ctl <= slpi_pkg::CTL_IDLE;
                if (ph == 3'h6) {oe, ph} <= '0;
            end
        end
    end
endmodule
`default_nettype wire

// [slpi_phy.sv]
`timescale 1ns/100ps
`default_nettype none
module slpi_phy #(
    parameter int LCLK_HALF  = slpi_pkg::LCLK_HALF_CYC,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire slpi_pkg::slpi_pin_in_s  pins_i,
    output slpi_pkg::slpi_pin_out_s      pins_o,
    input  wire logic                    rx_valid_i,
    input  wire slpi_pkg::slpi_word_s    rx_word_i,
    input  wire logic [2:0]              rx_speed_i,
    output logic                         rx_ready_o,
    input  wire logic                    stat_req_i,
    input  wire logic                    arb_win_i,
    output logic                         req_pend_o,
    output logic [2:0]                   req_type_o,
    output logic                         accel_o,
    output logic                         tx_valid_o,
    output logic [7:0]                   tx_data_o,
    output logic                         tx_end_o
);
    initial begin
        if (LCLK_HALF < 2 || LCLK_HALF > 4) begin
            $error("slpi_phy: LCLK_HALF must lie in 2..4");
        end
    end

    localparam logic [1:0] HALF_M1 = 2'(LCLK_HALF - 1);

    typedef struct packed {
        slpi_pkg::slpi_pin_in_s  pin_s1;
        slpi_pkg::slpi_pin_in_s  pin_s2;
        logic [1:0]              div;
        slpi_pkg::slpi_pin_out_s po;
        slpi_pkg::slpi_phase_e   st;
        logic                    lr_busy;
        logic [4:0]              lr_cnt;
        logic [15:0]             lr_sh;
        logic [2:0]              lr_type;
        logic                    req_pend;
        logic [2:0]              req_type;
        logic [2:0]              req_spd;
        logic                    rd_pend;
        logic [3:0]              rd_addr;
        logic                    stat_pend;
        logic                    accel;
        logic [15:0][7:0]        regs;
        logic [15:0]             st_sh;
        logic [2:0]              st_cnt;
        logic [2:0]              rx_spd;
        logic [7:0]              rx_sh;
        logic [3:0]              rx_left;
        logic                    rx_last;
        logic [2:0]              tx_spd;
        logic [7:0]              tx_sh;
        logic [3:0]              tx_cnt;
        logic                    tx_valid;
        logic [7:0]              tx_data;
        logic                    tx_end;
    } slpi_state_s;

    slpi_state_s         s_reg;
    slpi_state_s         s_next;
    logic                tick;
    logic                pop;
    logic                fifo_valid;
    slpi_pkg::slpi_word_s fifo_word;

    function automatic logic [3:0] lane_bits(input logic [2:0] spd);
        unique case (spd)
            slpi_pkg::SPD_S100: lane_bits = 4'h2;
            slpi_pkg::SPD_S200: lane_bits = 4'h4;
            slpi_pkg::SPD_S400: lane_bits = 4'h8;
            default:            lane_bits = 4'h0;
        endcase
    endfunction

    // Top bits of a byte on the high-numbered lanes, the rest driven low.
    function automatic logic [7:0] emit(input logic [7:0] b, input logic [3:0] l);
        unique case (l)
            4'h2:    emit = {b[7:6], 6'h00};
            4'h4:    emit = {b[7:4], 4'h0};
            default: emit = b;
        endcase
    endfunction

    function automatic logic [4:0] req_len(input logic [2:0] t);
        unique case (t)
            slpi_pkg::REQ_RD:    req_len = slpi_pkg::LEN_RD;
            slpi_pkg::REQ_WR:    req_len = slpi_pkg::LEN_WR;
            slpi_pkg::REQ_ACCEL: req_len = slpi_pkg::LEN_ACCEL;
            default:             req_len = slpi_pkg::LEN_BUS;
        endcase
    endfunction

    slpi_fifo #(
        .W     (9),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (rx_valid_i),
        .in_data_i   (rx_word_i),
        .in_ready_o  (rx_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_word),
        .out_ready_i (pop)
    );

    always_comb begin
        logic [15:0] nb;
        logic [4:0]  cnt1;
        logic [3:0]  sa;
        logic [3:0]  l;
        logic [7:0]  tb;
        nb     = {s_reg.lr_sh[14:0], s_reg.pin_s2.link_service_request_line};
        cnt1   = s_reg.lr_cnt + 5'h01;
        sa     = 4'h0;
        l      = 4'h0;
        tb     = 8'h00;
        s_next = s_reg;
        tick   = 1'b0;
        pop    = 1'b0;
        s_next.pin_s1    = pins_i;
        s_next.pin_s2    = s_reg.pin_s1;
        s_next.tx_valid  = 1'b0;
        s_next.tx_end    = 1'b0;
        s_next.stat_pend = s_reg.stat_pend || stat_req_i;
        if (!s_reg.pin_s2.pwr) begin
            s_next.div      = 2'h0;
            s_next.po       = '0;
            s_next.st       = slpi_pkg::P_IDLE;
            s_next.lr_busy  = 1'b0;
            s_next.req_pend = 1'b0;
            s_next.rd_pend  = 1'b0;
        end else begin
            if (s_reg.div == HALF_M1) begin
                s_next.div     = 2'h0;
                s_next.po.sclk = !s_reg.po.sclk;
                tick           = !s_reg.po.sclk;
            end else begin
                s_next.div = s_reg.div + 2'h1;
            end
        end
        if (tick) begin
            if (!s_reg.lr_busy) begin
                if (s_reg.pin_s2.link_service_request_line) begin
                    s_next.lr_busy = 1'b1;
                    s_next.lr_cnt  = 5'h00;
                    s_next.lr_sh   = 16'h0000;
                end
            end else begin
                s_next.lr_sh  = nb;
                s_next.lr_cnt = cnt1;
                if (cnt1 == slpi_pkg::LEN_TYPE) begin
                    s_next.lr_type = nb[2:0];
                    if (nb[2:0] == slpi_pkg::REQ_RSVD) begin
                        s_next.lr_busy = 1'b0;
                    end
                end else if (cnt1 == req_len(s_reg.lr_type)) begin
                    s_next.lr_busy = 1'b0;
                    unique case (s_reg.lr_type)
                        slpi_pkg::REQ_RD: begin
                            s_next.rd_pend = 1'b1;
                            s_next.rd_addr = nb[3:0];
                        end
                        slpi_pkg::REQ_WR: begin
                            s_next.regs[nb[11:8]] = nb[7:0];
                        end
                        slpi_pkg::REQ_ACCEL: begin
                            s_next.accel = nb[0];
                        end
                        default: begin
                            if (!(s_reg.st == slpi_pkg::P_RECV
                                  && (s_reg.lr_type == slpi_pkg::REQ_FAIR
                                      || s_reg.lr_type == slpi_pkg::REQ_PRI))) begin
                                s_next.req_pend = 1'b1;
                                s_next.req_type = s_reg.lr_type;
                                s_next.req_spd  = nb[2:0];
                            end
                        end
                    endcase
                end
            end
            unique case (s_reg.st)
                slpi_pkg::P_IDLE: begin
                    s_next.po.ctl    = slpi_pkg::CTL_IDLE;
                    s_next.po.d      = 8'h00;
                    s_next.po.ctl_oe = 1'b1;
                    s_next.po.d_oe   = 1'b1;
                    if (s_reg.rd_pend || s_reg.stat_pend) begin
                        sa = s_reg.rd_pend ? s_reg.rd_addr : 4'h0;
                        if (s_reg.rd_pend) begin
                            s_next.rd_pend = 1'b0;
                        end else begin
                            s_next.stat_pend = stat_req_i;
                        end
                        s_next.st     = slpi_pkg::P_STAT;
                        s_next.po.ctl = slpi_pkg::CTL_STATUS;
                        s_next.po.d   = {sa[3:2], 6'h00};
                        s_next.st_sh  = {sa[1:0], s_reg.regs[sa], 6'h00};
                        s_next.st_cnt = 3'h0;
                    end else if (fifo_valid) begin
                        pop           = 1'b1;
                        s_next.st     = slpi_pkg::P_RECV;
                        s_next.po.ctl = slpi_pkg::CTL_RECV;
                        s_next.rx_spd = (lane_bits(rx_speed_i) == 4'h0) ? slpi_pkg::SPD_S100
                                                                          : rx_speed_i;
                        if (s_next.req_type == slpi_pkg::REQ_FAIR
                            || s_next.req_type == slpi_pkg::REQ_PRI) begin
                            s_next.req_pend = 1'b0;
                        end
                    end else if (s_reg.req_pend && arb_win_i) begin
                        s_next.st       = slpi_pkg::P_GRANT;
                        s_next.po.ctl   = slpi_pkg::CTL_GRANT;
                        s_next.tx_spd   = s_reg.req_spd;
                        s_next.req_pend = 1'b0;
                    end
                end
                slpi_pkg::P_STAT: begin
                    if (s_reg.st_cnt == slpi_pkg::STAT_LAST_CHUNK) begin
                        s_next.st     = slpi_pkg::P_IDLE;
                        s_next.po.ctl = slpi_pkg::CTL_IDLE;
                        s_next.po.d   = 8'h00;
                    end else begin
                        s_next.po.d   = {s_reg.st_sh[15:14], 6'h00};
                        s_next.st_sh  = {s_reg.st_sh[13:0], 2'h0};
                        s_next.st_cnt = s_reg.st_cnt + 3'h1;
                    end
                end
                slpi_pkg::P_RECV: begin
                    l = lane_bits(s_reg.rx_spd);
                    if (s_reg.rx_left != 4'h0) begin
                        s_next.po.d    = emit(s_reg.rx_sh, l);
                        s_next.rx_sh   = s_reg.rx_sh << l;
                        s_next.rx_left = s_reg.rx_left - l;
                    end else if (!s_reg.rx_last && fifo_valid) begin
                        pop = 1'b1;
                    end else begin
                        s_next.st     = slpi_pkg::P_IDLE;
                        s_next.po.ctl = slpi_pkg::CTL_IDLE;
                        s_next.po.d   = 8'h00;
                    end
                end
                slpi_pkg::P_GRANT: begin
                    // hand both buses to the link
                    s_next.st        = slpi_pkg::P_LINK;
                    s_next.po.ctl    = slpi_pkg::CTL_IDLE;
                    s_next.po.d      = 8'h00;
                    s_next.po.ctl_oe = 1'b0;
                    s_next.po.d_oe   = 1'b0;
                    s_next.tx_cnt    = 4'h0;
                end
                slpi_pkg::P_LINK: begin
                    l = lane_bits(s_reg.tx_spd);
                    unique case (s_reg.pin_s2.ctl)
                        slpi_pkg::CTL_XMIT: begin
                            if (l != 4'h0) begin
                                tb            = (s_reg.tx_sh << l) | (s_reg.pin_s2.d >> (4'h8 - l));
                                s_next.tx_sh  = tb;
                                s_next.tx_cnt = s_reg.tx_cnt + l;
                                if (s_reg.tx_cnt + l == 4'h8) begin
                                    s_next.tx_valid = 1'b1;
                                    s_next.tx_data  = tb;
                                    s_next.tx_cnt   = 4'h0;
                                end
                            end
                        end
                        slpi_pkg::CTL_IDLE: begin
                            s_next.st        = slpi_pkg::P_IDLE;
                            s_next.tx_end    = 1'b1;
                            s_next.po.ctl_oe = 1'b1;
                            s_next.po.d_oe   = 1'b1;
                        end
                        // hold keeps the link as owner
                        default: begin
                            s_next.st = slpi_pkg::P_LINK;
                        end
                    endcase
                end
                default: begin
                    s_next.st = slpi_pkg::P_IDLE;
                end
            endcase
            if (pop) begin
                l              = lane_bits(s_next.rx_spd);
                s_next.rx_last = fifo_word.last;
                s_next.po.d    = emit(fifo_word.data, l);
                s_next.rx_sh   = fifo_word.data << l;
                s_next.rx_left = 4'h8 - l;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pins_o     = s_reg.po;
    assign req_pend_o = s_reg.req_pend;
    assign req_type_o = s_reg.req_type;
    assign accel_o    = s_reg.accel;
    assign tx_valid_o = s_reg.tx_valid;
    assign tx_data_o  = s_reg.tx_data;
    assign tx_end_o   = s_reg.tx_end;

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    a_clock_high_time: assert property (@(posedge clk_i) disable iff (rst_i || !s_reg.pin_s2.pwr)
        $rose(s_reg.po.sclk) |-> s_reg.po.sclk[*3] ##1 !s_reg.po.sclk)
        else $error("interface clock high time wrong");
    a_ctl_on_edge: assert property (@(posedge clk_i) disable iff (rst_i || !s_reg.pin_s2.pwr)
        $changed(s_reg.po.ctl) |-> $rose(s_reg.po.sclk))
        else $error("control changed away from a rising edge");
    a_recv_lanes_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_reg.st == slpi_pkg::P_RECV && s_reg.rx_spd == slpi_pkg::SPD_S100) |-> s_reg.po.d[5:0] == 6'h00)
        else $error("unused lanes not low during S100 receive");
    a_stat_lanes_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_reg.st == slpi_pkg::P_STAT) |-> (s_reg.po.d[5:0] == 6'h00 && s_reg.po.ctl == slpi_pkg::CTL_STATUS))
        else $error("status transfer drives wrong code or lanes");
    a_grant_release: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_reg.st == slpi_pkg::P_GRANT && tick) |=> (!s_reg.po.ctl_oe && !s_reg.po.d_oe ##1 s_reg.st == slpi_pkg::P_LINK))
        else $error("buses not released after grant");
    a_stat_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(s_reg.st == slpi_pkg::P_STAT) |-> $past(s_reg.rd_pend || s_reg.stat_pend))
        else $error("status transfer without cause");
    a_recv_code: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_reg.st == slpi_pkg::P_RECV) |-> (s_reg.po.ctl == slpi_pkg::CTL_RECV && s_reg.po.ctl_oe))
        else $error("receive without receive code");
    a_grant_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(s_reg.st == slpi_pkg::P_GRANT) |-> $past(s_reg.req_pend && arb_win_i) && !s_reg.req_pend)
        else $error("grant without a won bus request");
    a_fair_lost: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_reg.st == slpi_pkg::P_RECV && s_reg.req_pend) |->
            (s_reg.req_type != slpi_pkg::REQ_FAIR && s_reg.req_type != slpi_pkg::REQ_PRI))
        else $error("fair or priority request survived receive");
endmodule
`default_nettype wire

// [slpi_pkg.sv]
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package slpi_pkg;

    // Control codes driven by this side.
    localparam logic [1:0] CTL_IDLE   = 2'h0;
    localparam logic [1:0] CTL_STATUS = 2'h1;
    localparam logic [1:0] CTL_RECV   = 2'h2;
    localparam logic [1:0] CTL_GRANT  = 2'h3;
    // Control codes driven by the link.
    localparam logic [1:0] CTL_HOLD   = 2'h1;
    localparam logic [1:0] CTL_XMIT   = 2'h2;

    // Request types.
    localparam logic [2:0] REQ_IMM   = 3'h0;
    localparam logic [2:0] REQ_ISO   = 3'h1;
    localparam logic [2:0] REQ_PRI   = 3'h2;
    localparam logic [2:0] REQ_FAIR  = 3'h3;
    localparam logic [2:0] REQ_RD    = 3'h4;
    localparam logic [2:0] REQ_WR    = 3'h5;
    localparam logic [2:0] REQ_ACCEL = 3'h6;
    localparam logic [2:0] REQ_RSVD  = 3'h7;

    // Speed codes.
    localparam logic [2:0] SPD_S100 = 3'h0;
    localparam logic [2:0] SPD_S200 = 3'h2;
    localparam logic [2:0] SPD_S400 = 3'h4;

    // Request bits counted after the start bit, up to but not including the stop bit.
    localparam logic [4:0] LEN_TYPE  = 5'h03;
    localparam logic [4:0] LEN_BUS   = 5'h06;
    localparam logic [4:0] LEN_RD    = 5'h07;
    localparam logic [4:0] LEN_WR    = 5'h0f;
    localparam logic [4:0] LEN_ACCEL = 5'h04;

    // Status word is sent two bits per interface clock.
    localparam logic [2:0] STAT_LAST_CHUNK = 3'h7;

    // Interface clock period and the half period in system clocks.
    localparam int LCLK_PERIOD_PS = 20345;
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int LCLK_HALF_CYC  = (LCLK_PERIOD_PS + 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS);

    typedef enum logic [2:0] {
        P_IDLE  = 3'b000,
        P_STAT  = 3'b001,
        P_RECV  = 3'b010,
        P_GRANT = 3'b011,
        P_LINK  = 3'b100
    } slpi_phase_e;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } slpi_word_s;

    typedef struct packed {
        logic [1:0] ctl;
        logic [7:0] d;
        logic       link_service_request_line;
        logic       pwr;
    } slpi_pin_in_s;

    typedef struct packed {
        logic       sclk;
        logic [1:0] ctl;
        logic       ctl_oe;
        logic [7:0] d;
        logic       d_oe;
    } slpi_pin_out_s;

endpackage

// [test_slpi_phy.sv]
`timescale 1ns/100ps
`default_nettype none
module test_slpi_phy;
    logic clk_i = 0, rst_i = 1, pwr = 0, go = 0, rx_valid = 0, arb_win = 0;
    logic [16:0] req = 17'h0_0000;
    logic [7:0] tx_b = 8'h00, tx_data, rx_b;
    logic rx_ready, req_pend, accel, tx_valid, tx_end, rx_stb;
    logic [2:0] req_type;
    slpi_pkg::slpi_word_s rx_word = '0;
    slpi_pkg::slpi_pin_in_s pins_i;
    slpi_pkg::slpi_pin_out_s pins_o;
    int error_cnt = 0, samples_checked = 0, ends = 0;
    logic [7:0] txq[$], rxq[$];
    logic stat_req = 0, sclk_q = 0;
    logic [15:0] stw = '0;
    logic [7:0] wd = 8'h00;
    int scnt = 0, n0 = 0;
    slpi_phy DUT (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins_i), .pins_o(pins_o),
        .rx_valid_i(rx_valid), .rx_word_i(rx_word), .rx_speed_i(slpi_pkg::SPD_S400),
        .rx_ready_o(rx_ready), .stat_req_i(stat_req), .arb_win_i(arb_win), .req_pend_o(req_pend),
        .req_type_o(req_type), .accel_o(accel), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
        .tx_end_o(tx_end));
    slpi_link_model link (.clk_i(clk_i), .rst_i(rst_i), .pwr_i(pwr), .phy_i(pins_o),
        .pins_o(pins_i), .go_i(go), .req_i(req), .tx_i(tx_b), .rx_stb_o(rx_stb), .rx_o(rx_b));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic send(input logic [16:0] r);
        req = r;
        go = 1'b1;
        step(1);
        go = 1'b0;
        step(120);
    endtask
    initial forever #2 clk_i = ~clk_i;
    initial begin
        #300000;
        error_cnt++;
        test_done();
    end
    always @(posedge clk_i) begin
        if (tx_valid === 1'b1) chk(tx_data, txq.size() ? txq.pop_front() : 8'hxx);
        if (rx_stb === 1'b1) chk(rx_b, rxq.size() ? rxq.pop_front() : 8'hxx);
        if (tx_end === 1'b1) ends++;
        sclk_q <= pins_o.sclk;
        if (pins_o.sclk && !sclk_q && pins_o.ctl_oe && pins_o.ctl == slpi_pkg::CTL_STATUS) begin
            stw <= {stw[13:0], pins_o.d[7:6]};
            scnt <= scnt + 1;
        end
    end
    initial begin
        void'($urandom(32'hf0e3));
        step(8);
        rst_i = 1'b0;
        pwr = 1'b1;
        step(20);
        for (int t = 0; t < 4; t++) begin
            tx_b = 8'($urandom);
            send({1'b1, 3'(t), 3'h4, 1'b0, 9'h000});
            chk({4'h0, req_pend, req_type}, {5'h01, 3'(t)});
            for (int k = 0; k < 3; k++) txq.push_back(tx_b + 8'(k));
            arb_win = 1'b1;
            for (int w = 0; w < 400 && ends == t; w++) step(1);
            chk(8'(ends), 8'(t + 1));
            arb_win = 1'b0;
        end
        send({1'b1, 3'h7, 13'h0000});
        chk({7'h00, req_pend}, 8'h00);
        send({1'b1, 3'h6, 1'b1, 1'b0, 11'h000});
        chk({7'h00, accel}, 8'h01);
        wd = 8'($urandom);
        send({1'b1, 3'h5, 4'h5, wd, 1'b0});
        n0 = scnt;
        send({1'b1, 3'h4, 4'h5, 9'h000});
        step(30);
        chk(8'(scnt - n0), 8'h08);
        chk(stw[15:8], {4'h5, wd[7:4]});
        chk(stw[7:0], {wd[3:0], 4'h0});
        n0 = scnt;
        stat_req = 1'b1;
        step(1);
        stat_req = 1'b0;
        step(80);
        chk(8'(scnt - n0), 8'h08);
        chk(stw[15:8], 8'h00);
        pwr = 1'b0;
        step(12);
        chk({5'h00, pins_o.sclk, pins_o.ctl_oe, pins_o.d_oe}, 8'h00);
        pwr = 1'b1;
        step(20);
        rx_valid = 1'b1;
        for (int n = 0; n < 24; n++) begin
            rx_word.data = 8'($urandom);
            rx_word.last = (n == 23);
            rxq.push_back(rx_word.data);
            for (int w = 0; w < 200 && rx_ready !== 1'b1; w++) step(1);
            step(1);
        end
        rx_valid = 1'b0;
        step(400);
        chk(8'(rxq.size() + txq.size()), 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
